// file: hw/cbf_pkg.sv
/*
  Package for the current-block access and freewheel link logic:
  register offsets, write masks, reset values, field codes and sizes.
  Assumes a 16-bit register port addressed by the printed word offsets.
*/
`default_nettype none
package cbf_pkg;
  // ****************************************************************
  // register map (word offsets on the register port)
  // ****************************************************************
  localparam logic [9:0]  ADDR_GRANT_CH1   = 10'h166;
  localparam logic [9:0]  ADDR_GRANT_CH2   = 10'h167;
  localparam logic [9:0]  ADDR_GRANT_CH3   = 10'h168;
  localparam logic [9:0]  ADDR_FREEWHEEL_PARTNER_MAP     = 10'h169;
  localparam logic [9:0]  ADDR_FW_FORCE    = 10'h16A;
  // writable bits; reserved bits read zero
  localparam logic [15:0] MASK_GRANT       = 16'hFFFF;
  localparam logic [15:0] MASK_FREEWHEEL_PARTNER_MAP     = 16'h78FF;
  localparam logic [15:0] MASK_FW_FORCE    = 16'h007F;
  localparam logic [15:0] RST_REG          = 16'h0000;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          GRANT_UC1_BASE   = 8;   // uc1 half of a grant
  localparam int          GB_B5_LOW        = 4;   // block 5 low grant
  localparam int          GB_B5_HIGH       = 5;   // block 5 high/neg grant
  localparam int          GB_B6_LOW        = 6;   // block 6 low grant
  localparam int          GB_B6_HIGH       = 7;   // block 6 high/neg grant
  localparam int          LINK_LS_BASE     = 0;   // low-side 1..7 partners
  localparam int          LINK_HS7_BIT     = 7;   // hs7 partner of hs1
  localparam int          LINK_FLAG_BASE   = 11;  // flag 0..3 partners
  localparam int          FLAG_HS_BASE     = 3;   // flag0 pairs with hs4
  // ****************************************************************
  // sizes and request field codes
  // ****************************************************************
  localparam int          N_CORE           = 6;   // uc0ch1..uc1ch3
  localparam int          N_BLOCK          = 6;
  localparam int          N_FIELD          = 5;
  localparam int          N_HS             = 7;
  localparam int          N_FLAG           = 4;
  localparam logic [2:0]  FLD_DAC          = 3'h0; // dac / low dac
  localparam logic [2:0]  FLD_GAIN         = 3'h1;
  localparam logic [2:0]  FLD_OFS          = 3'h2; // offset-trim request
  localparam logic [2:0]  FLD_DAC_HIGH     = 3'h3; // blocks 5, 6 only
  localparam logic [2:0]  FLD_DAC_NEG      = 3'h4; // blocks 5, 6 only
  localparam int          BLK_FOUR         = 3;   // pin-shared block
  localparam int          BLK_FIVE         = 4;
endpackage : cbf_pkg
`default_nettype wire

// file: hw/cbf_pick.sv
/*
  Fixed-priority picker for one control signal of one measurement block.
  Assumes request bits are already gated by access grants; index 0 has
  the highest priority.
*/
`timescale 1ns/1ps
`default_nettype none
module cbf_pick #(
  parameter int NREQ = 6,
  parameter int DW   = 8
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // gated requests, data packed per requester
  input  wire logic [NREQ-1:0]      req,
  input  wire logic [NREQ*DW-1:0]   req_data,
  // applied value and its one-cycle update strobe
  output logic                      upd_r,
  output logic [DW-1:0]             val_r
);
  // elaboration check: the picker needs a requester and a data bit
  if (NREQ < 1 || DW < 1)
  begin : g_bad_param
    $error("cbf_pick: bad parameters");
  end

  logic          upd_nxt;  // any request this cycle
  logic [DW-1:0] val_nxt;  // winning value or held value

  // scan from lowest priority up so the highest wins a collision
  always_comb
  begin
    upd_nxt = 1'b0;
    val_nxt = val_r;
    for (int i = NREQ - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        upd_nxt = 1'b1;
        val_nxt = req_data[i*DW +: DW];
      end
    end
  end

  // value holds between requests: requesters send changes, not levels
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      upd_r <= 1'b0;
      val_r <= '0;
    end
    else
    begin
      upd_r <= upd_nxt;
      val_r <= val_nxt;
    end
  end
endmodule // cbf_pick
`default_nettype wire

// file: hw/cbf_access_fw.sv
/*
  Current-block access grants and freewheel partner logic.
  Holds three grant registers, the freewheel link map and the freewheel
  force register; arbitrates microcore change requests onto block
  control signals; drives freewheel partner outputs.
  Assumes: one change request per microcore per cycle, synchronous
  inputs, and a single-cycle register read/write port.
*/
// Summary of operation
// R1: ungranted microcore requests to a block ignored
// R2: three 16-bit grant registers, uc0 low byte
// R3: block 5/6 low and high grants separate
// R4: microcores send discrete change requests only
// R5: same-cycle collision applies exactly one value
// R6: requests in different cycles applied in order
// R7: block four enabled only by flag config
// R8: link register selects partner for freewheel
// R9: link bits 0-6 pair low-side N, high-side N
// R10: link bits 11-14 pair flags with hs4..hs7
// R11: a link bit pairs hs7 with hs1
// R12: force bits activate freewheel, else microcore request
// R13: forcing works without running microcode
// R14: priority ch1 before ch2 before ch3, uc0 first
`timescale 1ns/1ps
`default_nettype none
module cbf_access_fw #(
  parameter int DW = 8  // width of each block control value
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // register port
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  input  wire logic [9:0]                    reg_addr,
  input  wire logic [15:0]                   reg_wdata,
  output logic [15:0]                        reg_rdata_r,
  // microcore change requests, index = channel*2 + core
  input  wire logic [cbf_pkg::N_CORE-1:0]    mc_req_valid,
  input  wire logic [cbf_pkg::N_CORE*3-1:0]  mc_req_block,
  input  wire logic [cbf_pkg::N_CORE*3-1:0]  mc_req_field,
  input  wire logic [cbf_pkg::N_CORE*DW-1:0] mc_req_data,
  // block four pin select from the flag source and direction settings
  input  wire logic                          cur4_flag_select,
  output logic                               cur4_meas_enable_r,
  // block controls, index = block*N_FIELD + field
  output logic [cbf_pkg::N_BLOCK*cbf_pkg::N_FIELD-1:0]    cm_upd,
  output logic [cbf_pkg::N_BLOCK*cbf_pkg::N_FIELD*DW-1:0] cm_val,
  // freewheel
  input  wire logic [cbf_pkg::N_HS-1:0]      mc_freewheel_req,
  output logic [cbf_pkg::N_HS-1:0]           ls_freewheel_drive_r,
  output logic [cbf_pkg::N_FLAG-1:0]         flag_freewheel_drive_r,
  output logic                               hs7_freewheel_drive_r
);
  localparam int NT = cbf_pkg::N_BLOCK * cbf_pkg::N_FIELD;

  // elaboration check: values travel on 16-bit request lanes at most
  if (DW < 1 || DW > 16)
  begin : g_bad_dw
    $error("cbf_access_fw: DW out of range");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] grant_r   [3];  // per-channel grants
  logic [15:0] grant_nxt [3];
  logic [15:0] link_r;         // freewheel partner map
  logic [15:0] link_nxt;
  logic [15:0] force_r;        // freewheel force bits
  logic [15:0] force_nxt;
  logic [15:0] rdata_nxt;
  logic        cur4_nxt;

  // register writes and read mux
  always_comb
  begin
    for (int c = 0; c < 3; c++)
      grant_nxt[c] = grant_r[c];
    link_nxt  = link_r;
    force_nxt = force_r;
    rdata_nxt = reg_rdata_r;
    // R7 block four select
    cur4_nxt  = cur4_flag_select;
    if (reg_wr_en)
    begin
      case (reg_addr)
        // R2 grant writes
        cbf_pkg::ADDR_GRANT_CH1: grant_nxt[0] = reg_wdata & cbf_pkg::MASK_GRANT;
        cbf_pkg::ADDR_GRANT_CH2: grant_nxt[1] = reg_wdata & cbf_pkg::MASK_GRANT;
        cbf_pkg::ADDR_GRANT_CH3: grant_nxt[2] = reg_wdata & cbf_pkg::MASK_GRANT;
        // R8 partner map write
        cbf_pkg::ADDR_FREEWHEEL_PARTNER_MAP:   link_nxt  = reg_wdata & cbf_pkg::MASK_FREEWHEEL_PARTNER_MAP;
        cbf_pkg::ADDR_FW_FORCE:  force_nxt = reg_wdata & cbf_pkg::MASK_FW_FORCE;
        default:                 ;  // unmapped writes dropped
      endcase
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        cbf_pkg::ADDR_GRANT_CH1: rdata_nxt = grant_r[0];
        cbf_pkg::ADDR_GRANT_CH2: rdata_nxt = grant_r[1];
        cbf_pkg::ADDR_GRANT_CH3: rdata_nxt = grant_r[2];
        cbf_pkg::ADDR_FREEWHEEL_PARTNER_MAP:   rdata_nxt = link_r;
        cbf_pkg::ADDR_FW_FORCE:  rdata_nxt = force_r;
        default:                 rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int c = 0; c < 3; c++)
        grant_r[c] <= cbf_pkg::RST_REG;
      link_r             <= cbf_pkg::RST_REG;
      force_r            <= cbf_pkg::RST_REG;
      reg_rdata_r        <= 16'h0000;
      cur4_meas_enable_r <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < 3; c++)
        grant_r[c] <= grant_nxt[c];
      link_r             <= link_nxt;
      force_r            <= force_nxt;
      reg_rdata_r        <= rdata_nxt;
      cur4_meas_enable_r <= cur4_nxt;
    end
  end

  // ****************************************************************
  // access gating and arbitration
  // ****************************************************************
  // grant bit position within a core's byte for a block and field
  function automatic int grant_bit(input int b, input int f);
    int r;
    r = b;
    // R3 blocks five and six split low and high grants
    if (b == cbf_pkg::BLK_FIVE)
      r = (f >= 3) ? cbf_pkg::GB_B5_HIGH : cbf_pkg::GB_B5_LOW;
    else if (b > cbf_pkg::BLK_FIVE)
      r = (f >= 3) ? cbf_pkg::GB_B6_HIGH : cbf_pkg::GB_B6_LOW;
    return r;
  endfunction

  logic [cbf_pkg::N_CORE-1:0] gq [NT];  // gated requests per target

  // requests stay discrete: a request is one cycle of valid
  always_comb
  begin
    for (int t = 0; t < NT; t++)
    begin
      for (int i = 0; i < cbf_pkg::N_CORE; i++)
      begin
        // R1 grant gates every request
        gq[t][i] = mc_req_valid[i]
          && (int'(mc_req_block[i*3 +: 3]) == t / cbf_pkg::N_FIELD)
          && (int'(mc_req_field[i*3 +: 3]) == t % cbf_pkg::N_FIELD)
          && grant_r[i/2][(i%2)*cbf_pkg::GRANT_UC1_BASE
                          + grant_bit(t / cbf_pkg::N_FIELD,
                                      t % cbf_pkg::N_FIELD)];
        // R7 block four only while its pins serve measurement
        if (t / cbf_pkg::N_FIELD == cbf_pkg::BLK_FOUR && !cur4_meas_enable_r)
          gq[t][i] = 1'b0;
      end
    end
  end

  // per-target nets: each slice has its own driver, outputs copy them
  wire logic [NT-1:0]    upd_w;  // per-target update strobes
  wire logic [NT*DW-1:0] val_w;  // per-target held values

  // one picker per real control signal; high/neg exist on 5 and 6 only
  for (genvar t = 0; t < NT; t++)
  begin : g_tgt
    if ((t % cbf_pkg::N_FIELD) < 3
        || (t / cbf_pkg::N_FIELD) >= cbf_pkg::BLK_FIVE)
    begin : g_pick
      // R5 R6 R14 one winner, lower index first, each cycle applied
      cbf_pick #(.NREQ(cbf_pkg::N_CORE), .DW(DW)) u_pick (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .req      (gq[t]),
        .req_data (mc_req_data),
        .upd_r    (upd_w[t]),
        .val_r    (val_w[t*DW +: DW])
      );
    end
    else
    begin : g_none
      assign upd_w[t]          = 1'b0;
      assign val_w[t*DW +: DW] = '0;
    end
  end

  // single driver for each output vector
  assign cm_upd = upd_w;
  assign cm_val = val_w;

  // ****************************************************************
  // freewheel partners
  // ****************************************************************
  logic [cbf_pkg::N_HS-1:0]   fw_active;  // per high-side
  logic [cbf_pkg::N_HS-1:0]   ls_nxt;
  logic [cbf_pkg::N_FLAG-1:0] flag_nxt;
  logic                       hs7_nxt;

  // force bits need no microcode, so a stalled core cannot block them
  always_comb
  begin
    // R12 R13 force or microcore request
    fw_active = force_r[cbf_pkg::N_HS-1:0] | mc_freewheel_req;
    // R9 low-side N partners high-side N
    for (int n = 0; n < cbf_pkg::N_HS; n++)
      ls_nxt[n] = link_r[cbf_pkg::LINK_LS_BASE + n] & fw_active[n];
    // R10 flags partner hs4..hs7
    for (int k = 0; k < cbf_pkg::N_FLAG; k++)
      flag_nxt[k] = link_r[cbf_pkg::LINK_FLAG_BASE + k]
                    & fw_active[cbf_pkg::FLAG_HS_BASE + k];
    // R11 hs7 partners hs1
    hs7_nxt = link_r[cbf_pkg::LINK_HS7_BIT] & fw_active[0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ls_freewheel_drive_r   <= '0;
      flag_freewheel_drive_r <= '0;
      hs7_freewheel_drive_r  <= 1'b0;
    end
    else
    begin
      ls_freewheel_drive_r   <= ls_nxt;
      flag_freewheel_drive_r <= flag_nxt;
      hs7_freewheel_drive_r  <= hs7_nxt;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // core 0 alone on block 1 dac
  logic solo0;
  assign solo0 = mc_req_valid == 6'h01 && mc_req_block[2:0] == 3'h0
                 && mc_req_field[2:0] == cbf_pkg::FLD_DAC;

  grant_gate_a: assert property (solo0 && !grant_r[0][0] |=> !cm_upd[0]) // R1
    else $error("ungranted request applied");
  solo_apply_a: assert property (solo0 && grant_r[0][0] // R6
      |=> cm_upd[0] && cm_val[DW-1:0] == $past(mc_req_data[DW-1:0]))
    else $error("granted request not applied");
  collide_pick_a: assert property (mc_req_valid[1:0] == 2'h3 // R14
      && mc_req_block[5:0] == 6'h00 && mc_req_field[5:0] == 6'h00
      && grant_r[0][0] && grant_r[0][8] && !mc_req_valid[2]
      |=> cm_val[DW-1:0] == $past(mc_req_data[DW-1:0]))
    else $error("collision winner wrong");
  hi_gate_a: assert property (mc_req_valid == 6'h01 // R3
      && mc_req_block[2:0] == 3'h4
      && mc_req_field[2:0] == cbf_pkg::FLD_DAC_HIGH
      && grant_r[0][4] && !grant_r[0][5] |=> !cm_upd[23])
    else $error("high dac gated by low grant");
  grant_wr_a: assert property (reg_wr_en // R2
      && reg_addr == cbf_pkg::ADDR_GRANT_CH2
      |=> grant_r[1] == $past(reg_wdata))
    else $error("grant write lost");
  cur4_gate_a: assert property (!cur4_meas_enable_r |=> !cm_upd[15]) // R7
    else $error("block four updated while pins digital");
  force_fw_a: assert property (force_r[0] && link_r[0] // R13
      |=> ls_freewheel_drive_r[0])
    else $error("force did not drive partner");
  idle_fw_a: assert property (!force_r[1] && !mc_freewheel_req[1] // R12
      |=> !ls_freewheel_drive_r[1])
    else $error("freewheel without cause");
  ls_pair_a: assert property (link_r[3] && mc_freewheel_req[3] // R9
      |=> ls_freewheel_drive_r[3])
    else $error("low-side 4 not paired with hs4");
  flag_fw_a: assert property (link_r[11] && mc_freewheel_req[3] // R10
      |=> flag_freewheel_drive_r[0])
    else $error("flag0 not paired with hs4");
  hs7_fw_a: assert property (link_r[7] && force_r[0] // R11
      |=> hs7_freewheel_drive_r)
    else $error("hs7 not paired with hs1");

  collide_c: cover property (mc_req_valid[1:0] == 2'h3 && grant_r[0][0]);
  seq_c:     cover property (cm_upd[0] ##1 cm_upd[0]);
  force_c:   cover property (force_r[0] && link_r[0] && !mc_freewheel_req[0]);
endmodule // cbf_access_fw
`default_nettype wire

// file: bench/cbf_core_model.sv
/*
  Model of the six microcores on the request side of the block.
  Assumes the bench calls fire() at a falling edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module cbf_core_model (
  // clock
  input  wire logic        clk_sys,
  // change requests, index = channel*2 + core
  output logic [5:0]       mc_req_valid,
  output logic [17:0]      mc_req_block,
  output logic [17:0]      mc_req_field,
  output logic [47:0]      mc_req_data
);
  // idle: no request, lines parked at an arbitrary pattern
  initial
  begin
    mc_req_valid = 6'h00;
    mc_req_block = 18'h00000;
    mc_req_field = 18'h00000;
    mc_req_data  = 48'hA5A5_A5A5_A5A5;
  end
  // one-cycle change request
  // core i sends d^i so the winner of a collision can be told apart
  task automatic fire(input logic [5:0] m, input logic [2:0] b,
                      input logic [2:0] f, input logic [7:0] d);
    for (int i = 0; i < 6; i++)
    begin
      mc_req_block[i*3+:3] = b;
      mc_req_field[i*3+:3] = f;
      mc_req_data[i*8+:8]  = d ^ 8'(i);
    end
    mc_req_valid = m;
    @(negedge clk_sys);
    // released data and block lines show the inverse so stale values never match
    mc_req_valid = 6'h00;
    mc_req_data  = ~mc_req_data;
    mc_req_block = ~mc_req_block;
  endtask
endmodule // cbf_core_model
`default_nettype wire

// file: bench/testbench.sv
/*
  Self-checking bench for cbf_access_fw: registers, grants, collisions,
  block four select and freewheel partners.
  Assumes inputs are driven at the falling edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // clock, reset and register port
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         reg_wr_en = 1'b0;
  logic         reg_rd_en = 1'b0;
  logic [9:0]   reg_addr = 10'h000;
  logic [15:0]  reg_wdata = 16'h0000;
  logic [15:0]  reg_rdata_r;
  // requests, block controls and freewheel
  wire  [5:0]   mc_req_valid;
  wire  [17:0]  mc_req_block;
  wire  [17:0]  mc_req_field;
  wire  [47:0]  mc_req_data;
  logic         cur4_flag_select = 1'b0;
  logic         cur4_meas_enable_r;
  logic [29:0]  cm_upd;
  logic [239:0] cm_val;
  logic [6:0]   mc_freewheel_req = 7'h00;
  logic [6:0]   ls_freewheel_drive_r;
  logic [3:0]   flag_freewheel_drive_r;
  logic         hs7_freewheel_drive_r;
  int           fails = 0;
  int           num_checks = 0;
  int           cycles = 0;
  always #4 clk_sys = ~clk_sys;
  cbf_access_fw #(.DW(8)) u_cbf_access_fw (.clk_sys(clk_sys), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .mc_req_valid(mc_req_valid), .mc_req_block(mc_req_block),
    .mc_req_field(mc_req_field), .mc_req_data(mc_req_data),
    .cur4_flag_select(cur4_flag_select),
    .cur4_meas_enable_r(cur4_meas_enable_r), .cm_upd(cm_upd),
    .cm_val(cm_val), .mc_freewheel_req(mc_freewheel_req),
    .ls_freewheel_drive_r(ls_freewheel_drive_r),
    .flag_freewheel_drive_r(flag_freewheel_drive_r),
    .hs7_freewheel_drive_r(hs7_freewheel_drive_r));
  cbf_core_model u_cbf_core_model (.clk_sys(clk_sys),
    .mc_req_valid(mc_req_valid), .mc_req_block(mc_req_block),
    .mc_req_field(mc_req_field), .mc_req_data(mc_req_data));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // write strobe held for exactly one rising edge
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    @(negedge clk_sys);
  endtask
  // read data lands on the read edge and is taken at the next falling edge
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    reg_rd_en = 1'b1; reg_addr = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    d = reg_rdata_r;
    @(negedge clk_sys);
  endtask
  // fire one request set, then judge strobe and value of target b*5+f
  task automatic req(input logic [5:0] m, input logic [2:0] b, f,
                     input logic [7:0] d, input logic u, input logic [7:0] v);
    int t;
    t = int'(b) * 5 + int'(f);
    u_cbf_core_model.fire(m, b, f, d);
    chk("cm_upd", {15'h0000, cm_upd[t]}, {15'h0000, u});
    chk("cm_val", {8'h00, cm_val[t*8+:8]}, {8'h00, v});
    // strobe stands one cycle and the value holds; the gap also keeps
    // valid low for an edge before the next request raises it again
    @(negedge clk_sys);
    chk("cm_upd_idle", {15'h0000, cm_upd[t]}, 16'h0000);
    chk("cm_val_hold", {8'h00, cm_val[t*8+:8]}, {8'h00, v});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [15:0] d;
    for (logic [9:0] a = 10'h166; a <= 10'h16B; a++)
    begin
      rd(a, d);
      chk("reset", d, 16'h0000);
      wr(a, 16'hFFFF);
      rd(a, d);
      chk("mask", d, a < 10'h169 ? cbf_pkg::MASK_GRANT : a == 10'h169 ?
          cbf_pkg::MASK_FREEWHEEL_PARTNER_MAP : a == 10'h16A ? cbf_pkg::MASK_FW_FORCE :
          16'h0000);
      wr(a, 16'h0000);
    end
  endtask
  task automatic t_grant();
    req(6'h01, 3'h0, cbf_pkg::FLD_DAC, 8'h5A, 1'b0, 8'h00);
    wr(cbf_pkg::ADDR_GRANT_CH1, 16'h0001);
    req(6'h01, 3'h0, cbf_pkg::FLD_DAC, 8'h5A, 1'b1, 8'h5A);
    req(6'h02, 3'h0, cbf_pkg::FLD_DAC, 8'h33, 1'b0, 8'h5A);
    wr(cbf_pkg::ADDR_GRANT_CH1, 16'h0100);
    req(6'h02, 3'h0, cbf_pkg::FLD_DAC, 8'h33, 1'b1, 8'h32);
  endtask
  task automatic t_split();
    wr(cbf_pkg::ADDR_GRANT_CH1, 16'h0001 << cbf_pkg::GB_B5_LOW);
    req(6'h01, 3'h4, cbf_pkg::FLD_DAC_HIGH, 8'h11, 1'b0, 8'h00);
    req(6'h01, 3'h4, cbf_pkg::FLD_GAIN, 8'h22, 1'b1, 8'h22);
    wr(cbf_pkg::ADDR_GRANT_CH1, 16'h0001 << cbf_pkg::GB_B5_HIGH);
    req(6'h01, 3'h4, cbf_pkg::FLD_DAC_NEG, 8'h66, 1'b1, 8'h66);
    req(6'h01, 3'h4, cbf_pkg::FLD_DAC, 8'h77, 1'b0, 8'h00);
  endtask
  task automatic t_collide();
    wr(cbf_pkg::ADDR_GRANT_CH1, 16'hFFFF);
    wr(cbf_pkg::ADDR_GRANT_CH2, 16'hFFFF);
    wr(cbf_pkg::ADDR_GRANT_CH3, 16'hFFFF);
    req(6'h03, 3'h0, cbf_pkg::FLD_DAC, 8'h90, 1'b1, 8'h90);
    req(6'h3E, 3'h1, cbf_pkg::FLD_OFS, 8'hC0, 1'b1, 8'hC1);
    req(6'h30, 3'h1, cbf_pkg::FLD_OFS, 8'hC0, 1'b1, 8'hC4);
    req(6'h20, 3'h1, cbf_pkg::FLD_OFS, 8'h70, 1'b1, 8'h75);
    req(6'h04, 3'h1, cbf_pkg::FLD_OFS, 8'h70, 1'b1, 8'h72);
  endtask
  task automatic t_blk4();
    req(6'h01, 3'h3, cbf_pkg::FLD_DAC, 8'h44, 1'b0, 8'h00);
    cur4_flag_select = 1'b1;
    @(negedge clk_sys);
    chk("cur4_meas_enable_r", {15'h0000, cur4_meas_enable_r}, 16'h0001);
    req(6'h01, 3'h3, cbf_pkg::FLD_DAC, 8'h44, 1'b1, 8'h44);
  endtask
  task automatic fw(input logic [15:0] e);
    @(negedge clk_sys);
    chk("freewheel", {4'h0, hs7_freewheel_drive_r, flag_freewheel_drive_r,
        ls_freewheel_drive_r}, e);
  endtask
  task automatic t_fw();
    wr(cbf_pkg::ADDR_FW_FORCE, 16'h007F);
    fw(16'h0000);
    wr(cbf_pkg::ADDR_FREEWHEEL_PARTNER_MAP, 16'h78FF);
    fw(16'h0FFF);
    wr(cbf_pkg::ADDR_FW_FORCE, 16'h0000);
    fw(16'h0000);
    mc_freewheel_req = 7'h09;
    @(negedge clk_sys);
    fw(16'h0889);
  endtask
  // mid-run reset clears registers, held values and partner drives
  task automatic t_reset();
    logic [15:0] d;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    fw(16'h0000);
    chk("cm_val_rst", {8'h00, cm_val[7:0]}, 16'h0000);
    rd(cbf_pkg::ADDR_GRANT_CH1, d);
    chk("grant_rst", d, cbf_pkg::RST_REG);
  endtask
  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    t_regs();
    t_grant();
    t_split();
    t_collide();
    t_blk4();
    t_fw();
    t_reset();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
